// >>> fault_readback.sv
// module: fault readback status word with read-to-clear flags
`timescale 1ns/1ps
// Function
// RULE_01 - fault word at offset 1, resets zero
// RULE_02 - odd bits 23..9 open flags, read-clear
// RULE_03 - even bits 22..8 short flags, read-clear
// RULE_04 - bit 7 thermal shutdown, read-clear
// RULE_05 - bit 6 command error, read-clear
// RULE_06 - bits 5..0 read-only config checksum
// RULE_07 - eight pins open-drain or diagnostic
// RULE_08 - diag enable high selects diagnostic mode
// RULE_09 - power-on reset loads all defaults
// RULE_10 - standby enable high holds defaults
// RULE_11 - persistent fault re-sets after clearing
module fault_readback
   import fault_readback_pkg::*;
(
   input  wire logic        i_clk,            // serial interface clock domain
   input  wire logic        i_rst_n,          // power-on reset, active low
   input  wire logic        i_standby,        // enable pin, high = standby
   input  wire logic [23:0] i_config,         // configuration register contents
   input  wire logic        i_rd_strobe,      // one-cycle read of register
   input  wire logic [0:0]  i_rd_offset,      // register index being read
   input  wire logic [7:0]  i_open_det,       // open detected per pair (async)
   input  wire logic [7:0]  i_short_det,      // short detected per pair (async)
   input  wire logic        i_thermal_det,    // thermal shutdown detected (async)
   input  wire logic        i_cmd_err_det,    // command error event, same clock
   output logic      [23:0] o_rd_data,        // registered readback word
   output logic      [7:0]  o_diag_mode       // pair in diagnostic mode
);
   //--------------------------------------------------
   // synchronisers for analog detector levels
   //--------------------------------------------------
   logic [16:0] sync1_ff;                     // first stage, read by stage two only
   logic [16:0] sync2_ff;                     // second stage
   logic [16:0] nxt_sync1;
   logic [16:0] nxt_sync2;
   always_comb begin
      nxt_sync1 = {i_thermal_det, i_short_det, i_open_det};
      nxt_sync2 = sync1_ff;
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_ff <= 17'h00000;
         sync2_ff <= 17'h00000;
      end else begin
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
      end
   end
   //--------------------------------------------------
   // diagnostic mode per pair
   //--------------------------------------------------
   // a low bit leaves the pin an ordinary open-drain switch
   always_comb begin
      o_diag_mode = i_config[DIAG_EN_LSB +: PAIRS]; // RULE_07 RULE_08
   end
   //--------------------------------------------------
   // flag state
   //--------------------------------------------------
   logic [7:0]  open_ff;                      // open flags per pair
   logic [7:0]  short_ff;                     // short flags per pair
   logic        thermal_ff;                   // thermal shutdown flag
   logic        cmd_err_ff;                   // command error flag
   logic [5:0]  csum_ff;                      // registered checksum
   logic [23:0] rd_data_ff;                   // readback output
   logic [7:0]  nxt_open;
   logic [7:0]  nxt_short;
   logic        nxt_thermal;
   logic        nxt_cmd_err;
   logic [5:0]  nxt_csum;
   logic [23:0] nxt_rd_data;
   logic [5:0]  csum_calc;
   logic        rd_fault;
   logic [23:0] word;

   config_checksum u_csum (
      .i_config (i_config),
      .o_csum   (csum_calc)
   );

   // assemble the word from current flags
   always_comb begin
      word = FAULT_RESET;
      for (int p = 0; p < PAIRS; p++) begin
         word[OPEN_LSB + 2*p]  = open_ff[p];  // RULE_02
         word[SHORT_LSB + 2*p] = short_ff[p]; // RULE_03
      end
      word[THERMAL_BIT]  = thermal_ff;        // RULE_04
      word[CMD_ERR_BIT]  = cmd_err_ff;        // RULE_05
      word[CSUM_W-1:0]   = csum_ff;           // RULE_06
   end

   // next state: a detection in the clear cycle wins over the clear
   always_comb begin
      rd_fault    = i_rd_strobe && (i_rd_offset == FAULT_OFFSET); // RULE_01
      nxt_open    = open_ff;
      nxt_short   = short_ff;
      nxt_thermal = thermal_ff;
      nxt_cmd_err = cmd_err_ff;
      nxt_rd_data = rd_data_ff;
      nxt_csum    = csum_calc;                // RULE_06
      if (rd_fault) begin
         nxt_rd_data = word;                  // RULE_01
         nxt_open    = 8'h00;                 // RULE_02
         nxt_short   = 8'h00;                 // RULE_03
         nxt_thermal = 1'b0;                  // RULE_04
         nxt_cmd_err = 1'b0;                  // RULE_05
      end else if (i_rd_strobe) begin
         nxt_rd_data = FAULT_RESET;           // config is write-only, reads zero
      end
      // only diagnostic pairs may raise flags; re-detection sets again
      nxt_open    = nxt_open  | (sync2_ff[7:0]  & o_diag_mode); // RULE_08 RULE_11
      nxt_short   = nxt_short | (sync2_ff[15:8] & o_diag_mode); // RULE_08 RULE_11
      nxt_thermal = nxt_thermal | sync2_ff[16];                  // RULE_11
      nxt_cmd_err = nxt_cmd_err | i_cmd_err_det;                 // RULE_05
      if (i_standby) begin                    // standby forces defaults
         nxt_open    = 8'h00;                 // RULE_10
         nxt_short   = 8'h00;
         nxt_thermal = 1'b0;
         nxt_cmd_err = 1'b0;
         nxt_csum    = CSUM_RESET;
         nxt_rd_data = FAULT_RESET;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin                     // RULE_09
         open_ff    <= 8'h00;
         short_ff   <= 8'h00;
         thermal_ff <= 1'b0;
         cmd_err_ff <= 1'b0;
         csum_ff    <= CSUM_RESET;
         rd_data_ff <= FAULT_RESET;
      end else begin
         open_ff    <= nxt_open;
         short_ff   <= nxt_short;
         thermal_ff <= nxt_thermal;
         cmd_err_ff <= nxt_cmd_err;
         csum_ff    <= nxt_csum;
         rd_data_ff <= nxt_rd_data;
      end
   end

   always_comb begin
      o_rd_data = rd_data_ff;
   end

   //--------------------------------------------------
   // assertions
   //--------------------------------------------------
   property p_read_clears;
      @(posedge i_clk) disable iff (!i_rst_n)
      (rd_fault && !i_standby && sync2_ff == 17'h00000 && !i_cmd_err_det)
         |=> (open_ff == 8'h00 && short_ff == 8'h00 && !thermal_ff && !cmd_err_ff);
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flags not cleared"); // RULE_02

   property p_read_data;
      @(posedge i_clk) disable iff (!i_rst_n)
      (rd_fault && !i_standby) |=> (o_rd_data == $past(word));
   endproperty
   a_read_data: assert property (p_read_data) else $error("readback word wrong"); // RULE_01

   property p_set_wins;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!i_standby && sync2_ff[0] && o_diag_mode[0]) |=> open_ff[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("open flag lost"); // RULE_11

   // a clear short flag on plain-output pair 6 must stay clear whatever the detector says
   property p_no_flag_off_mode;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!o_diag_mode[6] && !short_ff[6]) |=> !short_ff[6];
   endproperty
   a_no_flag_off_mode: assert property (p_no_flag_off_mode) else $error("short in plain mode"); // RULE_08

   property p_thermal_sticky;
      @(posedge i_clk) disable iff (!i_rst_n)
      (thermal_ff && !rd_fault && !i_standby) |=> thermal_ff;
   endproperty
   a_thermal_sticky: assert property (p_thermal_sticky) else $error("thermal dropped"); // RULE_04

   property p_cmd_err_set;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_cmd_err_det && !i_standby) |=> cmd_err_ff;
   endproperty
   a_cmd_err_set: assert property (p_cmd_err_set) else $error("cmd error missed"); // RULE_05

   property p_csum_tracks;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!i_standby && $stable(i_config)) ##1 (!i_standby && rd_fault)
         |=> (o_rd_data[5:0] == $past(csum_calc, 2));
   endproperty
   a_csum_tracks: assert property (p_csum_tracks) else $error("checksum wrong"); // RULE_06

   property p_standby_defaults;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_standby |=> (word == FAULT_RESET && o_rd_data == FAULT_RESET);
   endproperty
   a_standby_defaults: assert property (p_standby_defaults) else $error("standby state"); // RULE_10

   c_read_flag: cover property (@(posedge i_clk) disable iff (!i_rst_n) rd_fault && open_ff != 8'h00);
   c_reset_again: cover property (@(posedge i_clk) disable iff (!i_rst_n)
      rd_fault ##1 open_ff[0]);
   c_standby: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_standby && thermal_ff);
endmodule // fault_readback

// >>> fault_readback_pkg.sv
// package: offsets, field positions, reset values of the fault readback word
package fault_readback_pkg;
   //--------------------------------------------------
   // register map
   //--------------------------------------------------
   localparam logic [0:0]  CONFIG_OFFSET   = 1'h0;   // configuration register index
   localparam logic [0:0]  FAULT_OFFSET    = 1'h1;   // fault readback register index
   localparam int          WORD_W          = 24;     // register width
   localparam int          PAIRS           = 8;      // diagnostic channel pairs
   localparam logic [23:0] FAULT_RESET     = 24'h000000;
   localparam logic [5:0]  CSUM_RESET      = 6'h00;
   //--------------------------------------------------
   // field positions
   //--------------------------------------------------
   localparam int          OPEN_LSB        = 9;      // open flags at 9,11..23
   localparam int          SHORT_LSB       = 8;      // short flags at 8,10..22
   localparam int          THERMAL_BIT     = 7;
   localparam int          CMD_ERR_BIT     = 6;
   localparam int          CSUM_W          = 6;      // checksum bits 5..0
   localparam int          DIAG_EN_LSB     = 16;     // diag enables in config 23..16
   localparam logic [6:0]  CSUM_POLY       = 7'h43;  // checksum polynomial x^6+x+1
endpackage

// >>> config_checksum.sv
// module: 6-bit checksum over the 24-bit configuration word
`timescale 1ns/1ps
module config_checksum
   import fault_readback_pkg::*;
(
   input  wire logic [23:0] i_config,   // configuration register contents
   output logic      [5:0]  o_csum      // checksum remainder
);
   //--------------------------------------------------
   // bitwise polynomial division, msb first
   //--------------------------------------------------
   // purely combinational; the caller registers the result
   always_comb begin
      logic [5:0] rem;
      logic       fb;
      rem = CSUM_RESET;
      fb  = 1'b0;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         fb  = rem[5] ^ i_config[i];
         rem = {rem[4:0], 1'b0} ^ (fb ? CSUM_POLY[5:0] : 6'h00);
      end
      o_csum = rem;
   end
endmodule // config_checksum

// >>> host_model.sv
// host model: issues one register read at a time and captures the returned word
`timescale 1ns/1ps
module host_model (
   input  wire logic        i_clk,        // serial interface clock
   input  wire logic        i_go,         // request one read
   input  wire logic        i_off,        // register index to read
   input  wire logic [23:0] i_rd_data,    // word answered by the device
   output logic             o_rd_strobe,  // one-cycle read request
   output logic      [0:0]  o_rd_offset,  // index held through the request
   output logic      [23:0] o_word,       // captured answer
   output logic             o_done        // one-cycle capture flag
);
   //------------------------------------------------
   // read sequencer
   //------------------------------------------------
   logic [1:0] step_ff;  // position in the read sequence
   initial begin
      step_ff     = 2'h0;
      o_rd_strobe = 1'b0;
      o_rd_offset = 1'h0;
      o_word      = 24'h000000;
      o_done      = 1'b0;
   end
   // strobe lasts exactly one edge; a longer one would clear flags twice
   always @(posedge i_clk) begin
      o_done <= (step_ff == 2'h3);  // capture flag rises together with the captured word
      case (step_ff)
         2'h0: if (i_go) begin
            o_rd_strobe <= 1'b1;
            o_rd_offset <= i_off;
            step_ff     <= 2'h1;
         end
         2'h1: begin
            o_rd_strobe <= 1'b0;
            step_ff     <= 2'h2;
         end
         2'h2: step_ff <= 2'h3;  // device answer was registered at the previous edge; wait here
         default: begin
            o_word  <= i_rd_data;
            step_ff <= 2'h0;
         end
      endcase
   end
endmodule // host_model

// >>> led_fault_readback_register_tb.sv
// testbench: read-to-clear fault word, checksum, mode and standby behaviour
`timescale 1ns/1ps
module led_fault_readback_register_tb;
   import fault_readback_pkg::*;
   //------------------------------------------------
   // stimulus and observation signals
   //------------------------------------------------
   logic i_clk, i_rst_n, stby, go, off, th, cerr, strb, done;
   logic [0:0]  roff;
   logic [7:0]  op, sh, mode;
   logic [23:0] cfg, rdat, word;
   int miscompares, total_checks;
   fault_readback uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_standby(stby),
      .i_config(cfg), .i_rd_strobe(strb), .i_rd_offset(roff), .i_open_det(op),
      .i_short_det(sh), .i_thermal_det(th), .i_cmd_err_det(cerr),
      .o_rd_data(rdat), .o_diag_mode(mode));
   host_model host (.i_clk(i_clk), .i_go(go), .i_off(off), .i_rd_data(rdat),
      .o_rd_strobe(strb), .o_rd_offset(roff), .o_word(word), .o_done(done));
   //------------------------------------------------
   // helpers
   //------------------------------------------------
   // msb-first checksum, zero seed
   function automatic logic [5:0] crc6(input logic [23:0] d);
      logic [5:0] c;
      c = 6'h00;
      for (int i = 23; i >= 0; i--) begin
         c = (c[5] ^ d[i]) ? ({c[4:0], 1'b0} ^ CSUM_POLY[5:0]) : {c[4:0], 1'b0};
      end
      return c;
   endfunction
   // flags only count for pairs whose enable is set
   function automatic logic [23:0] expw(input logic [7:0] o, s, input logic t, e);
      logic [23:0] w;
      w = {16'h0000, t, e, crc6(cfg)};
      for (int p = 0; p < PAIRS; p++) begin
         w[OPEN_LSB+2*p]  = o[p] & cfg[DIAG_EN_LSB+p];
         w[SHORT_LSB+2*p] = s[p] & cfg[DIAG_EN_LSB+p];
      end
      return w;
   endfunction
   task automatic chk(input string n, input logic [23:0] e, g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // one read through the host model, bounded wait on its capture flag
   // the capture flag is looked at 1 ns after each edge, where it is settled
   task automatic rd(input logic o, input string n, input logic [23:0] e);
      int waited;
      waited = 0;
      @(posedge i_clk) go <= 1'b1;
      off <= o;
      @(posedge i_clk) go <= 1'b0;
      while (done !== 1'b1 && waited < 8) begin
         @(posedge i_clk);
         #1;
         waited++;
      end
      if (done !== 1'b1) begin
         miscompares++;
         $display("wrong value %s done expected 1 seen %b", n, done);
      end
      chk(n, e, word);
   endtask
   // detections held long enough to pass the two-flop synchroniser
   task automatic fault(input logic [7:0] o, s, input logic t);
      @(posedge i_clk) op <= o;
      sh <= s;
      th <= t;
      cyc(5);
      op <= 8'h00;
      sh <= 8'h00;
      th <= 1'b0;
      cyc(5);
   endtask
   //------------------------------------------------
   // scenarios
   //------------------------------------------------
   task automatic t_flags(input logic [23:0] c);
      @(posedge i_clk) cfg <= c;
      fault(8'h81, 8'h42, 1'b0);
      chk("mode", {16'h0000, c[23:16]}, {16'h0000, mode});
      rd(1'b1, "flags", expw(8'h81, 8'h42, 1'b0, 1'b0));
      rd(1'b1, "cleared", expw(8'h00, 8'h00, 1'b0, 1'b0));
      $display("test flags done cfg %h", c);
   endtask
   task automatic t_misc();
      @(posedge i_clk) cerr <= 1'b1;
      @(posedge i_clk) cerr <= 1'b0;
      fault(8'h00, 8'h00, 1'b1);
      rd(1'b0, "offset zero", 24'h000000);
      rd(1'b1, "thermal cmd", expw(8'h00, 8'h00, 1'b1, 1'b1));
      rd(1'b1, "thermal clr", expw(8'h00, 8'h00, 1'b0, 1'b0));
      $display("test thermal and command error done");
   endtask
   task automatic t_persist();
      // pair 0 is still in diagnostic mode from the previous config
      @(posedge i_clk) op <= 8'h01;
      cyc(5);
      rd(1'b1, "persist a", expw(8'h01, 8'h00, 1'b0, 1'b0));
      rd(1'b1, "persist b", expw(8'h01, 8'h00, 1'b0, 1'b0));
      @(posedge i_clk) op <= 8'h00;
      cyc(5);
      rd(1'b1, "persist c", expw(8'h01, 8'h00, 1'b0, 1'b0));
      rd(1'b1, "persist d", expw(8'h00, 8'h00, 1'b0, 1'b0));
      $display("test persistent fault done");
   endtask
   // second power-on reset with flags pending: all must return to defaults
   task automatic t_reset();
      fault(8'h01, 8'h02, 1'b1);
      @(posedge i_clk) i_rst_n <= 1'b0;
      cyc(3);
      @(posedge i_clk) i_rst_n <= 1'b1;
      rd(1'b1, "after reset", expw(8'h00, 8'h00, 1'b0, 1'b0));
      $display("test mid-run reset done");
   endtask
   task automatic t_standby();
      fault(8'h00, 8'h20, 1'b1);
      @(posedge i_clk) stby <= 1'b1;
      rd(1'b1, "standby", 24'h000000);
      @(posedge i_clk) stby <= 1'b0;
      cyc(3);
      rd(1'b1, "after standby", expw(8'h00, 8'h00, 1'b0, 1'b0));
      $display("test standby done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   //------------------------------------------------
   // clock, reset, sequence and watchdog
   //------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      {i_rst_n, stby, go, off, th, cerr, op, sh, cfg} = '0;
      miscompares = 0;
      total_checks = 0;
      cyc(3);
      @(posedge i_clk) i_rst_n <= 1'b1;
      rd(1'b1, "reset word", 24'h000000);
      t_flags(24'hff0000);
      t_flags(24'h0f00aa);
      t_misc();
      t_persist();
      t_reset();
      t_standby();
      print_verdict();
   end
   initial begin
      cyc(3000);
      miscompares++;
      print_verdict();
   end
endmodule // led_fault_readback_register_tb
